// ### core/dmap_addr_former.sv
// Bus address formation and address increment for the access path
module dmap_addr_former
	import dmap_pkg::*;
(
	input wire logic [31:0] xfer_addr,
	input wire dmap_win_type win,
	input wire logic [11:0] offset,
	input wire logic [2:0] size,
	output logic [31:0] bus_addr,
	output logic [31:0] addr_step
);

	always_comb begin
		unique case (win)
			WIN_DATA: bus_addr = xfer_addr;
			WIN_BANK: bus_addr = {xfer_addr[31:4], offset[3:0]};
			WIN_DAW: bus_addr = {xfer_addr[31:10], offset[9:0]};
			default: bus_addr = xfer_addr;
		endcase
	end

	// Transfer address stepped by the byte count of the access size; reserved sizes step as a word
	always_comb begin
		unique case (size)
			SIZE_BYTE: addr_step = xfer_addr + 32'h1;
			SIZE_HALF: addr_step = xfer_addr + 32'h2;
			default: addr_step = xfer_addr + 32'h4;
		endcase
	end

endmodule : dmap_addr_former

// ### core/dmap_bridge.sv
// Debug memory access path: upstream register port to single downstream bus transfers
module dmap_bridge
	import dmap_pkg::*;
(
	input wire logic sys_clk,
	input wire logic reset,
	input wire logic port_enable_input,
	input wire logic abort_req,
	input wire logic [11:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic [31:0] haddr,
	output logic [1:0] htrans,
	output logic hwrite,
	output logic [2:0] hsize,
	output logic [31:0] hwdata,
	input wire logic [31:0] hrdata,
	input wire logic hready,
	input wire logic hresp,
	output logic transfer_pending_flag,
	output logic port_enable_status
);

	dmap_regs_type st_r;
	dmap_regs_type st_nxt;
	dmap_win_type win;
	logic [31:0] bus_addr;
	logic [31:0] addr_step;
	logic [31:0] ctrl_word;
	logic access;
	logic is_mem;
	logic inc_ok;

	dmap_addr_former u_addr (
		.xfer_addr(st_r.xfer_addr),
		.win(win),
		.offset(paddr),
		.size(st_r.ctrl_size),
		.bus_addr(bus_addr),
		.addr_step(addr_step)
	);

	assign access = psel && penable && (st_r.fsm == ST_IDLE);

	// Window decode; banked windows other than zero are not present and read as zero
	always_comb begin
		win = WIN_DATA;
		is_mem = 1'b0;
		if (paddr == OFS_DATA) begin
			is_mem = 1'b1;
		end else if (paddr == OFS_BANK0) begin
			win = WIN_BANK;
			is_mem = 1'b1;
		end else if (paddr < DAW_LIMIT) begin
			win = WIN_DAW;
			is_mem = 1'b1;
		end
	end

	// Status word as software reads it; reserved bits read as zero
	always_comb begin
		ctrl_word = 32'h0;
		ctrl_word[CTRL_SIZE_LSB +: 3] = st_r.ctrl_size;
		ctrl_word[CTRL_INC_LSB +: 2] = st_r.ctrl_inc;
		ctrl_word[CTRL_EN_BIT] = st_r.en_sync;
		ctrl_word[CTRL_PEND_BIT] = st_r.pend;
	end

	// Abort seen in the finishing cycle counts too, so a late abort still blocks the step
	assign inc_ok = st_r.is_data_reg && (st_r.ctrl_inc == INC_SINGLE) && !hresp
		&& !st_r.aborted && !abort_req;

	always_comb begin
		st_nxt = st_r;
		st_nxt.en_meta = port_enable_input;
		st_nxt.en_sync = st_r.en_meta;
		st_nxt.pready = 1'b0;
		unique case (st_r.fsm)
			ST_IDLE: begin
				if (access) begin
					st_nxt.pslverr = 1'b0;
					st_nxt.prdata = 32'h0;
					st_nxt.fsm = ST_RESP;
					if (is_mem) begin
						if (!st_r.en_sync) begin
							// Blocked access finishes at once with an error
							st_nxt.pready = 1'b1;
							st_nxt.pslverr = 1'b1;
						end else begin
							st_nxt.ahb.haddr = bus_addr;
							st_nxt.ahb.htrans = HTRANS_NONSEQ;
							st_nxt.ahb.hwrite = pwrite;
							st_nxt.ahb.hsize = st_r.ctrl_size;
							if (pwrite) begin
								st_nxt.data = pwdata;
							end
							st_nxt.is_data_reg = (win == WIN_DATA);
							st_nxt.aborted = 1'b0;
							st_nxt.pend = 1'b1;
							st_nxt.fsm = ST_ADDR;
						end
					end else begin
						st_nxt.pready = 1'b1;
						if (pwrite) begin
							if (paddr == OFS_ADDR) begin
								st_nxt.xfer_addr = pwdata;
							end
							if (paddr == OFS_CTRL) begin
								st_nxt.ctrl_size = pwdata[CTRL_SIZE_LSB +: 3];
								st_nxt.ctrl_inc = pwdata[CTRL_INC_LSB +: 2];
							end
						end else if (paddr == OFS_ADDR) begin
							st_nxt.prdata = st_r.xfer_addr;
						end else if (paddr == OFS_CTRL) begin
							st_nxt.prdata = ctrl_word;
						end
					end
				end
			end
			ST_ADDR: begin
				if (abort_req) begin
					st_nxt.aborted = 1'b1;
				end
				if (hready) begin
					st_nxt.ahb.htrans = HTRANS_IDLE;
					st_nxt.ahb.hwdata = st_r.data;
					st_nxt.fsm = ST_DATA;
				end
			end
			ST_DATA: begin
				if (abort_req) begin
					st_nxt.aborted = 1'b1;
				end
				if (hready) begin
					st_nxt.pend = 1'b0;
					if (!st_r.ahb.hwrite) begin
						st_nxt.data = hrdata;
					end
					st_nxt.prdata = st_r.ahb.hwrite ? st_r.data : hrdata;
					st_nxt.pslverr = hresp;
					st_nxt.pready = 1'b1;
					if (inc_ok) begin
						st_nxt.xfer_addr = addr_step;
					end
					st_nxt.fsm = ST_RESP;
				end
			end
			ST_RESP: begin
				// Lets the upstream master drop its enable before a new access is seen
				st_nxt.fsm = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			st_r <= '0;
			st_r.fsm <= ST_IDLE;
			st_r.xfer_addr <= ADDR_RST;
			st_r.ctrl_size <= SIZE_RST;
			st_r.ctrl_inc <= INC_RST;
			st_r.ahb.htrans <= HTRANS_IDLE;
			st_r.ahb.hsize <= SIZE_RST;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign prdata = st_r.prdata;
	assign pready = st_r.pready;
	assign pslverr = st_r.pslverr;
	assign haddr = st_r.ahb.haddr;
	assign htrans = st_r.ahb.htrans;
	assign hwrite = st_r.ahb.hwrite;
	assign hsize = st_r.ahb.hsize;
	assign hwdata = st_r.ahb.hwdata;
	assign transfer_pending_flag = st_r.pend;
	assign port_enable_status = st_r.en_sync;

	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (reset);

	chk_inc_hold_err: assert property (
		(st_r.fsm == ST_DATA) && hready && hresp |=> $stable(st_r.xfer_addr)
	) else $error("transfer address moved after an error response");

	chk_abort_hold: assert property (
		(st_r.fsm == ST_DATA) && hready && (st_r.aborted || abort_req)
		|=> $stable(st_r.xfer_addr)
	) else $error("transfer address moved after an abort");

	chk_inc_off_hold: assert property (
		(st_r.fsm == ST_DATA) && hready && (st_r.ctrl_inc == INC_OFF)
		|=> $stable(st_r.xfer_addr)
	) else $error("transfer address moved with increment off");

	chk_size_drive: assert property (
		(htrans == HTRANS_NONSEQ) |-> (hsize == st_r.ctrl_size)
	) else $error("bus size differs from the size field");

	chk_addr_write: assert property (
		access && pwrite && (paddr == OFS_ADDR)
		|=> (st_r.xfer_addr == $past(pwdata)) && pready
	) else $error("transfer address write not taken");

	chk_reg_answer: assert property (
		access && !is_mem
		|=> pready && !pslverr
	) else $error("register access not answered in one cycle");

	chk_data_addr: assert property (
		access && (paddr == OFS_DATA) && st_r.en_sync
		|=> (htrans == HTRANS_NONSEQ) && (haddr == $past(st_r.xfer_addr))
	) else $error("data register access used a wrong address");

	chk_bank_addr: assert property (
		access && (paddr == OFS_BANK0) && st_r.en_sync
		|=> (haddr == {$past(st_r.xfer_addr[31:4]), 4'h0})
	) else $error("banked window zero used a wrong address");

	chk_bank_keep: assert property (
		(st_r.fsm == ST_DATA) && hready && !st_r.is_data_reg
		|=> $stable(st_r.xfer_addr)
	) else $error("window access moved the transfer address");

	chk_daw_addr: assert property (
		access && (paddr < DAW_LIMIT) && st_r.en_sync
		|=> (haddr == {$past(st_r.xfer_addr[31:10]), $past(paddr[9:0])})
	) else $error("direct window used a wrong address");

	chk_write_start: assert property (
		access && pwrite && (paddr == OFS_DATA) && st_r.en_sync
		|=> (htrans == HTRANS_NONSEQ) && hwrite
	) else $error("data register write did not start a bus write");

	chk_read_start: assert property (
		access && !pwrite && (paddr == OFS_DATA) && st_r.en_sync
		|=> (htrans == HTRANS_NONSEQ) && !hwrite
	) else $error("data register read did not start a bus read");

	chk_single_xfer: assert property (
		(st_r.fsm == ST_DATA) || (st_r.fsm == ST_RESP)
		|-> (htrans == HTRANS_IDLE)
	) else $error("more than one bus transfer per access");

	chk_read_keep: assert property (
		(st_r.fsm == ST_DATA) && hready && !hwrite
		|=> (st_r.data == $past(hrdata))
	) else $error("data register lost the fetched value");

	chk_write_keep: assert property (
		access && pwrite && is_mem && st_r.en_sync
		|=> (st_r.data == $past(pwdata))
	) else $error("data register lost the value to write");

	chk_pend_answer: assert property (
		$fell(transfer_pending_flag)
		|-> pready
	) else $error("pending flag dropped without an answer");

	chk_one_pulse: assert property (
		pready
		|=> !pready
	) else $error("answer stood longer than one cycle");

	chk_status_bit: assert property (
		access && !pwrite && (paddr == OFS_CTRL)
		|=> (prdata[CTRL_EN_BIT] == $past(port_enable_status))
	) else $error("enable status bit out of step");

	chk_write_data: assert property (
		(st_r.fsm == ST_ADDR) && hready && hwrite |=> (hwdata == st_r.data)
	) else $error("write data not on the bus in the data phase");

	chk_read_return: assert property (
		(st_r.fsm == ST_DATA) && hready && !hwrite
		|=> pready && (prdata == $past(hrdata)) ##1 !pready
	) else $error("read data not returned upstream");

	chk_pend_flag: assert property (
		transfer_pending_flag == ((st_r.fsm == ST_ADDR) || (st_r.fsm == ST_DATA))
	) else $error("pending flag out of step with the master");

	chk_no_xfer_off: assert property (
		access && is_mem && !st_r.en_sync |=> (htrans == HTRANS_IDLE) && pslverr && pready
	) else $error("transfer started while the port is disabled");

	chk_inc_step: assert property (
		(st_r.fsm == ST_DATA) && hready && inc_ok
		|=> (st_r.xfer_addr == $past(st_r.xfer_addr) + (($past(st_r.ctrl_size) > SIZE_WORD)
		? 32'h4 : (32'h1 << $past(st_r.ctrl_size))))
	) else $error("transfer address stepped by a wrong amount");

endmodule : dmap_bridge

// ### core/dmap_pkg.sv
// Shared constants and types for the debug memory access path
package dmap_pkg;

	// Register offsets on the upstream slave port
	localparam logic [11:0] OFS_CTRL = 12'hd00;
	localparam logic [11:0] OFS_ADDR = 12'hd04;
	localparam logic [11:0] OFS_DATA = 12'hd0c;
	localparam logic [11:0] OFS_BANK0 = 12'hd10;
	// Direct access window covers offsets below this limit
	localparam logic [11:0] DAW_LIMIT = 12'h400;

	// Control status word fields
	localparam int CTRL_SIZE_LSB = 0;
	localparam int CTRL_INC_LSB = 4;
	localparam int CTRL_EN_BIT = 6;
	localparam int CTRL_PEND_BIT = 7;
	localparam logic [2:0] SIZE_RST = 3'h2;
	localparam logic [1:0] INC_RST = 2'h0;
	localparam logic [31:0] ADDR_RST = 32'h0;

	// Field encodings
	localparam logic [1:0] INC_OFF = 2'h0;
	localparam logic [1:0] INC_SINGLE = 2'h1;
	localparam logic [2:0] SIZE_BYTE = 3'h0;
	localparam logic [2:0] SIZE_HALF = 3'h1;
	localparam logic [2:0] SIZE_WORD = 3'h2;
	localparam logic [1:0] HTRANS_IDLE = 2'h0;
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_ADDR = 2'b01,
		ST_DATA = 2'b10,
		ST_RESP = 2'b11
	} dmap_state_type;

	typedef enum logic [1:0] {
		WIN_DATA = 2'b00,
		WIN_BANK = 2'b01,
		WIN_DAW = 2'b10
	} dmap_win_type;

	// Downstream master request as it leaves the block
	typedef struct packed {
		logic [31:0] haddr;
		logic [1:0] htrans;
		logic hwrite;
		logic [2:0] hsize;
		logic [31:0] hwdata;
	} dmap_ahb_type;

	// All state of the bridge
	typedef struct packed {
		dmap_state_type fsm;
		logic [31:0] xfer_addr;
		logic [2:0] ctrl_size;
		logic [1:0] ctrl_inc;
		logic [31:0] data;
		dmap_ahb_type ahb;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
		logic pend;
		logic en_meta;
		logic en_sync;
		logic aborted;
		logic is_data_reg;
	} dmap_regs_type;

endpackage : dmap_pkg

// ### verification/debug_memory_access_path_test.sv
// Self-checking bench for the debug memory access path
module debug_memory_access_path_test;
	timeunit 1ns;
	timeprecision 1ps;
	import dmap_pkg::*;
	logic sys_clk, reset, en, abort_req, psel, penable, pwrite, err;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, haddr, hwdata, hrdata, err_addr, last_addr, last_wdata, rd;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic hwrite, hready, hresp, pready, pslverr, pend, en_st;
	logic [3:0] wait_cycles;
	int error_cnt, n_checks, xfer_cnt, x0, pend_cnt;
	dmap_bridge dmap_bridge_inst (.sys_clk, .reset, .port_enable_input(en), .abort_req, .paddr,
		.psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr, .haddr, .htrans, .hwrite,
		.hsize, .hwdata, .hrdata, .hready, .hresp, .transfer_pending_flag(pend),
		.port_enable_status(en_st));
	dmap_mem_model dmap_mem_model_inst (.sys_clk, .reset, .haddr, .htrans, .hwrite, .hwdata,
		.wait_cycles, .err_addr, .hrdata, .hready, .hresp, .last_addr, .last_wdata, .xfer_cnt);
	initial begin
		sys_clk = 0;
		forever #5 sys_clk = ~sys_clk;
	end
	// Only this process writes the counter; tests compare snapshots of it
	always @(posedge sys_clk) if (pend === 1'b1) pend_cnt <= pend_cnt + 1;
	task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("MISMATCH %s expected %h seen %h", name, exp, seen);
		end
	endtask : check
	// Request held until the edge where pready is high; answer taken at that edge
	task acc(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int n;
		@(negedge sys_clk);
		psel = 1;
		pwrite = wr;
		paddr = a;
		pwdata = d;
		@(negedge sys_clk);
		penable = 1;
		n = 0;
		do begin
			@(posedge sys_clk);
			n++;
		end while (pready !== 1'b1 && n < 40);
		rd = prdata;
		err = pslverr;
		if (n >= 40) error_cnt++;
		@(negedge sys_clk);
		psel = 0;
		penable = 0;
	endtask : acc
	task give_verdict;
		$display("checks %0d mismatches %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask : give_verdict
	initial begin
		#50000;
		error_cnt++;
		give_verdict;
	end
	initial begin
		reset = 1; en = 1; abort_req = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0;
		pwdata = 0; wait_cycles = 0; err_addr = 32'hffff_fff0;
		error_cnt = 0; n_checks = 0;
		repeat (4) @(posedge sys_clk);
		@(negedge sys_clk);
		reset = 0;
		repeat (3) @(posedge sys_clk);
		acc(0, OFS_CTRL, 0);
		check("ctrl_reset", rd, 32'h0000_0042);
		$display("test reset done");
		acc(1, OFS_ADDR, 32'h0000_0100);
		acc(1, OFS_CTRL, 32'h0000_0012);
		acc(1, OFS_DATA, 32'ha5a5_0001);
		check("wr_addr", last_addr, 32'h0000_0100);
		check("wr_data", last_wdata, 32'ha5a5_0001);
		acc(1, OFS_DATA, 32'h5a5a_0002);
		check("wr_addr2", last_addr, 32'h0000_0104);
		acc(0, OFS_ADDR, 0);
		check("addr_inc", rd, 32'h0000_0108);
		// Slow memory read with increment off
		wait_cycles = 4'h3;
		acc(1, OFS_ADDR, 32'h0000_0104);
		acc(1, OFS_CTRL, 32'h0000_0002);
		x0 = pend_cnt;
		acc(0, OFS_DATA, 0);
		check("rd_data", rd, 32'h5a5a_0002);
		check("pending", pend_cnt > x0, 1);
		acc(0, OFS_ADDR, 0);
		check("addr_hold", rd, 32'h0000_0104);
		wait_cycles = 4'h0;
		$display("test word path done");
		for (int s = 0; s < 3; s++) begin
			acc(1, OFS_ADDR, 32'h0000_0200);
			acc(1, OFS_CTRL, 32'h10 | s);
			acc(1, OFS_DATA, 0);
			check("size", hsize, s[2:0]);
			acc(0, OFS_ADDR, 0);
			check("size_step", rd, 32'h200 + (1 << s));
		end
		$display("test sizes done");
		err_addr = 32'h0000_0204;
		acc(1, OFS_DATA, 32'h1);
		check("err_resp", err, 1);
		err_addr = 32'hffff_fff0;
		abort_req = 1;
		acc(1, OFS_DATA, 32'h1);
		abort_req = 0;
		acc(0, OFS_ADDR, 0);
		check("addr_frozen", rd, 32'h0000_0204);
		$display("test error and abort done");
		acc(1, OFS_ADDR, 32'h2000_0034);
		acc(1, OFS_BANK0, 32'hbeef_0003);
		check("bank_addr", last_addr, 32'h2000_0030);
		acc(0, OFS_ADDR, 0);
		check("bank_keep", rd, 32'h2000_0034);
		acc(1, 12'h3f8, 0);
		check("daw_addr", last_addr, 32'h2000_03f8);
		acc(0, 12'hd20, 0);
		check("unmapped", rd, 0);
		$display("test windows done");
		// Enable crosses a two-flop synchroniser, so allow a few edges
		en = 0;
		repeat (4) @(negedge sys_clk);
		x0 = xfer_cnt;
		check("en_status", en_st, 0);
		acc(1, OFS_DATA, 32'h1);
		check("dis_err", err, 1);
		check("dis_xfer", xfer_cnt - x0, 0);
		acc(0, OFS_CTRL, 0);
		check("ctrl_off", rd, 32'h0000_0012);
		$display("test disabled port done");
		give_verdict;
	end
endmodule : debug_memory_access_path_test

// ### verification/dmap_mem_model.sv
// Behavioural downstream memory with wait states and one error address
module dmap_mem_model
	import dmap_pkg::*;
(
	input wire logic sys_clk,
	input wire logic reset,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [31:0] hwdata,
	input wire logic [3:0] wait_cycles,
	input wire logic [31:0] err_addr,
	output logic [31:0] hrdata,
	output logic hready,
	output logic hresp,
	output logic [31:0] last_addr,
	output logic [31:0] last_wdata,
	output int xfer_cnt
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [31:0] mem [256];
	logic dph;
	logic dwr;
	logic [3:0] cnt;
	assign hready = !dph || cnt == 4'h0;
	assign hresp = dph && cnt == 4'h0 && last_addr == err_addr;
	// Outside a read data phase the bus shows the inverse of the last value, never stale data
	assign hrdata = (dph && !dwr && hready) ? mem[last_addr[9:2]] : ~last_wdata;
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			dph <= 1'b0;
			cnt <= 4'h0;
			xfer_cnt <= 0;
		end else if (hready) begin
			if (dph && dwr) begin
				mem[last_addr[9:2]] <= hwdata;
				last_wdata <= hwdata;
			end
			dph <= htrans == HTRANS_NONSEQ;
			if (htrans == HTRANS_NONSEQ) begin
				last_addr <= haddr;
				dwr <= hwrite;
				cnt <= wait_cycles;
				xfer_cnt <= xfer_cnt + 1;
			end
		end else begin
			cnt <= cnt - 4'h1;
		end
	end
endmodule : dmap_mem_model
